// >>> cafs_defines.svh
`ifndef CAFS_DEFINES_SVH
`define CAFS_DEFINES_SVH

// Clock rate and probe interval
`define CAFS_CLK_MHZ 200
`define CAFS_PROBE_TIME_US 40
`define CAFS_PROBE_CYCLES (`CAFS_PROBE_TIME_US * `CAFS_CLK_MHZ)
`define CAFS_CNT_W 20

// Status output encoding, bit 1 = status_out_a, bit 0 = status_out_b
`define CAFS_ST_CHARGING 2'h2
`define CAFS_ST_DONE 2'h1
`define CAFS_ST_OFF 2'h0

`endif

// >>> cafs_pack_model.sv
`timescale 1ns/1ps
// ----------------
// Pack model
// ----------------
// Cell node: 0 below precondition, 1 below recharge, 2 above recharge, 3 regulation
module cafs_pack_model (
	input wire logic i_mclk,
	input wire logic i_present,
	input wire logic [1:0] i_level,
	input wire logic i_sink_en,
	input wire logic i_cond_en,
	input wire logic i_fast_en,
	output logic o_above_recharge,
	output logic o_above_precondition,
	output logic o_at_regulation
);
	logic [1:0] node_reg = 2'h0;
	// A bare node only holds charge on the output capacitor, so currents move it at once
	always_ff @(posedge i_mclk) begin
		if (i_present || !(i_sink_en || i_cond_en || i_fast_en)) begin
			node_reg <= i_level;
		end else if (i_sink_en) begin
			node_reg <= 2'h0;
		end else begin
			node_reg <= 2'h3;
		end
	end
	// Comparator levels seen by the sequencer
	assign o_above_recharge = node_reg >= 2'h2;
	assign o_above_precondition = node_reg >= 2'h1;
	assign o_at_regulation = node_reg == 2'h3;
endmodule

// >>> cafs_pkg.sv
package cafs_pkg;
	typedef enum logic [3:0] {
		CAFS_IDLE,
		CAFS_PRECHG,
		CAFS_FAST,
		CAFS_DONE,
		CAFS_PROBE_SINK,
		CAFS_PROBE_COND,
		CAFS_ABSENT,
		CAFS_FAULT_HI,
		CAFS_FAULT_LO
	} cafs_state_t;
endpackage

// >>> cafs_probe_timer.sv
`timescale 1ns/1ps
`include "cafs_defines.svh"
module cafs_probe_timer
	import cafs_pkg::*;
#(
	parameter logic [`CAFS_CNT_W-1:0] TERMINAL = `CAFS_CNT_W'(`CAFS_PROBE_CYCLES)
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	cafs_timer_if.tmr tif
);
	logic [`CAFS_CNT_W-1:0] cnt_reg, cnt_next;
	logic exp_reg, exp_next;

	// Count down from terminal after start; pulse expired at the end
	always_comb begin
		cnt_next = cnt_reg;
		exp_next = 1'b0;
		if (tif.start) begin
			cnt_next = TERMINAL - `CAFS_CNT_W'(1);
		end else if (cnt_reg != '0) begin
			cnt_next = cnt_reg - `CAFS_CNT_W'(1);
			exp_next = (cnt_reg == `CAFS_CNT_W'(1));
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end
	assign tif.expired = exp_reg;
endmodule

// >>> cafs_sequencer.sv
// Operation
// - After done, cell sagging to recharge level starts the absent test.
// - Phase one: probe sink for one interval, then check below precondition level.
// - Phase two: conditioning current one interval, then check above recharge level.
// - Both phases pass: report battery absent on status outputs.
// - Either phase fails: abandon test, start fresh charge cycle.
// - Without a pack, detection and charge attempts repeat forever.
// - Timer fault above recharge: hold until below, then clear and test.
// - Timer fault below recharge: removal-sense current on while below.
// - Low fault, cell rises above recharge: sense off, follow high path.
// - Power-on reset or enable toggle clears any pending timer fault.
// - Status: charging 10, done 01, absent/suspend/fault/sleep 00. I_SUSPEND is never read, so suspend leaves the status of the current state.
// - Enable falling edge restarts charge; enable high disables charging.
// - Precharge timer expiry before precondition level: stop charging, show fault.
`timescale 1ns/1ps
`include "cafs_defines.svh"
module cafs_sequencer
	import cafs_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RESET,
	input wire logic I_CHARGE_EN_N,
	input wire logic I_ABOVE_RECHARGE_LEVEL,
	input wire logic I_ABOVE_PRECONDITION_LEVEL,
	input wire logic I_AT_REGULATION_LEVEL,
	input wire logic I_TAPER_DONE,
	input wire logic I_PRECHG_TIMEOUT,
	input wire logic I_CHG_TIMEOUT,
	input wire logic I_SUSPEND,
	output logic O_STATUS_OUT_A,
	output logic O_STATUS_OUT_B,
	output logic O_PROBE_SINK_EN,
	output logic O_CONDITIONING_EN,
	output logic O_REMOVAL_SENSE_EN,
	output logic O_FAST_CHARGE_EN,
	output logic O_TIMER_RESET
);
	//----------------------------------------------------------------
	// State
	//----------------------------------------------------------------
	cafs_state_t state_reg, state_next;
	logic en_n_prev_reg;
	logic [1:0] stat_reg, stat_next;
	logic sink_reg, sink_next, cond_reg, cond_next, sense_reg, sense_next;
	logic fast_reg, fast_next, trst_reg, trst_next;
	logic restart;

	cafs_timer_if tif();
	cafs_probe_timer u_timer (
		.i_mclk(I_MCLK),
		.i_reset(I_RESET),
		.tif(tif.tmr)
	);

	// Enable falling edge restarts a charge cycle
	assign restart = en_n_prev_reg & ~I_CHARGE_EN_N;

	//----------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		tif.start = 1'b0;
		trst_next = 1'b0;
		if (I_CHARGE_EN_N) begin
			state_next = CAFS_IDLE;
		end else if (restart || state_reg == CAFS_IDLE) begin
			state_next = CAFS_PRECHG;
			trst_next = 1'b1;
		end else begin
			case (state_reg)
				CAFS_PRECHG: begin
					if (I_PRECHG_TIMEOUT && !I_ABOVE_PRECONDITION_LEVEL) begin
						state_next = I_ABOVE_RECHARGE_LEVEL ? CAFS_FAULT_HI : CAFS_FAULT_LO;
					end else if (I_ABOVE_PRECONDITION_LEVEL) begin
						state_next = CAFS_FAST;
					end
				end
				CAFS_FAST: begin
					if (I_CHG_TIMEOUT) begin
						state_next = I_ABOVE_RECHARGE_LEVEL ? CAFS_FAULT_HI : CAFS_FAULT_LO;
					end else if (I_TAPER_DONE && I_AT_REGULATION_LEVEL) begin
						state_next = CAFS_DONE;
					end
				end
				CAFS_DONE: begin
					if (!I_ABOVE_RECHARGE_LEVEL) begin
						state_next = CAFS_PROBE_SINK;
						tif.start = 1'b1;
					end
				end
				CAFS_PROBE_SINK: begin
					if (tif.expired) begin
						if (!I_ABOVE_PRECONDITION_LEVEL) begin
							state_next = CAFS_PROBE_COND;
							tif.start = 1'b1;
						end else begin
							state_next = CAFS_PRECHG;
							trst_next = 1'b1;
						end
					end
				end
				CAFS_PROBE_COND: begin
					if (tif.expired) begin
						state_next = I_ABOVE_RECHARGE_LEVEL ? CAFS_ABSENT : CAFS_PRECHG;
						trst_next = !I_ABOVE_RECHARGE_LEVEL;
					end
				end
				CAFS_ABSENT: begin
					// Retry charging once the floating node sags again
					if (!I_ABOVE_RECHARGE_LEVEL) begin
						state_next = CAFS_PRECHG;
						trst_next = 1'b1;
					end
				end
				CAFS_FAULT_LO: begin
					if (I_ABOVE_RECHARGE_LEVEL) begin
						state_next = CAFS_FAULT_HI;
					end
				end
				CAFS_FAULT_HI: begin
					if (!I_ABOVE_RECHARGE_LEVEL) begin
						state_next = CAFS_PROBE_SINK;
						tif.start = 1'b1;
					end
				end
				default: begin
					state_next = CAFS_IDLE;
				end
			endcase
		end
	end

	// Outputs decoded from the next state so they register with it
	always_comb begin
		sink_next = (state_next == CAFS_PROBE_SINK);
		cond_next = (state_next == CAFS_PROBE_COND) || (state_next == CAFS_PRECHG);
		sense_next = (state_next == CAFS_FAULT_LO);
		fast_next = (state_next == CAFS_FAST);
		case (state_next)
			CAFS_PRECHG, CAFS_FAST: stat_next = `CAFS_ST_CHARGING;
			CAFS_DONE: stat_next = `CAFS_ST_DONE;
			default: stat_next = `CAFS_ST_OFF;
		endcase
	end

	//----------------------------------------------------------------
	// Registers
	//----------------------------------------------------------------
	always_ff @(posedge I_MCLK) begin
		if (I_RESET) begin
			state_reg <= CAFS_IDLE;
			en_n_prev_reg <= 1'b1;
			stat_reg <= `CAFS_ST_OFF;
			sink_reg <= 1'b0;
			cond_reg <= 1'b0;
			sense_reg <= 1'b0;
			fast_reg <= 1'b0;
			trst_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			en_n_prev_reg <= I_CHARGE_EN_N;
			stat_reg <= stat_next;
			sink_reg <= sink_next;
			cond_reg <= cond_next;
			sense_reg <= sense_next;
			fast_reg <= fast_next;
			trst_reg <= trst_next;
		end
	end

	assign O_STATUS_OUT_A = stat_reg[1];
	assign O_STATUS_OUT_B = stat_reg[0];
	assign O_PROBE_SINK_EN = sink_reg;
	assign O_CONDITIONING_EN = cond_reg;
	assign O_REMOVAL_SENSE_EN = sense_reg;
	assign O_FAST_CHARGE_EN = fast_reg;
	assign O_TIMER_RESET = trst_reg;

	//----------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RESET);

	AST_ONE_HOT: assert property ($onehot0({sink_reg, cond_reg, sense_reg, fast_reg}))
		else $error("more than one current enable on");
	AST_DONE_TO_PROBE: assert property (state_reg == CAFS_DONE && !I_CHARGE_EN_N && en_n_prev_reg == I_CHARGE_EN_N
		&& !I_ABOVE_RECHARGE_LEVEL |=> state_reg == CAFS_PROBE_SINK && sink_reg)
		else $error("absent test not started");
	AST_SINK_FAIL: assert property (state_reg == CAFS_PROBE_SINK && tif.expired && !I_CHARGE_EN_N && !restart
		&& I_ABOVE_PRECONDITION_LEVEL |=> state_reg == CAFS_PRECHG && trst_reg)
		else $error("failed probe did not restart charge");
	AST_SINK_PASS: assert property (state_reg == CAFS_PROBE_SINK && tif.expired && !I_CHARGE_EN_N && !restart
		&& !I_ABOVE_PRECONDITION_LEVEL |=> cond_reg && !sink_reg)
		else $error("second phase not entered");
	AST_ABSENT: assert property (state_reg == CAFS_PROBE_COND && tif.expired && !I_CHARGE_EN_N && !restart
		&& I_ABOVE_RECHARGE_LEVEL |=> state_reg == CAFS_ABSENT && stat_reg == `CAFS_ST_OFF)
		else $error("absent not reported");
	AST_LO_SENSE: assert property (state_reg == CAFS_FAULT_LO |-> sense_reg && stat_reg == `CAFS_ST_OFF)
		else $error("sense current off in low fault");
	AST_LO_TO_HI: assert property (state_reg == CAFS_FAULT_LO && !I_CHARGE_EN_N && !restart
		&& I_ABOVE_RECHARGE_LEVEL |=> state_reg == CAFS_FAULT_HI && !sense_reg)
		else $error("low fault did not move to high path");
	AST_RESTART: assert property (restart |=> state_reg == CAFS_PRECHG && trst_reg ##1 !trst_reg || restart)
		else $error("enable toggle did not restart");
	AST_DISABLE: assert property (I_CHARGE_EN_N |=> !cond_reg && !fast_reg && stat_reg == `CAFS_ST_OFF)
		else $error("charging while disabled");
	AST_CHARGING_STAT: assert property (fast_reg |-> stat_reg == `CAFS_ST_CHARGING)
		else $error("charging status wrong");

	COV_ABSENT: cover property (state_reg == CAFS_ABSENT);
	COV_FAULT_LO_HI: cover property (state_reg == CAFS_FAULT_LO ##1 state_reg == CAFS_FAULT_HI);
	COV_DONE: cover property (state_reg == CAFS_DONE);
	COV_RETRY: cover property (state_reg == CAFS_ABSENT ##1 state_reg == CAFS_PRECHG);
endmodule

// >>> cafs_sequencer_tb.sv
`timescale 1ns/1ps
`include "cafs_defines.svh"
module cafs_sequencer_tb;
	localparam int PROBE = `CAFS_PROBE_CYCLES;
	logic I_MCLK = 0, I_RESET = 1, I_CHARGE_EN_N = 1, I_TAPER_DONE = 0;
	logic I_PRECHG_TIMEOUT = 0, I_CHG_TIMEOUT = 0, I_SUSPEND = 0, present = 1;
	logic [1:0] lvl = 2'h0;
	logic rch, pre, at_reg, a, b, sink, cond, sense, fast, tres;
	int fail_count = 0, cmp_count = 0, tr_cnt = 0, cyc = 0;
	wire [5:0] outs = {a, b, sink, cond, sense, fast};

	// Clock and cycle ceiling
	always #2.5 I_MCLK = ~I_MCLK;
	always @(posedge I_MCLK) begin
		cyc++;
		if (tres === 1'b1) tr_cnt++;
		if (cyc == 3 * PROBE + 3000) begin
			fail_count++;
			print_verdict();
		end
	end

	cafs_sequencer dut (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_CHARGE_EN_N(I_CHARGE_EN_N),
		.I_ABOVE_RECHARGE_LEVEL(rch), .I_ABOVE_PRECONDITION_LEVEL(pre), .I_AT_REGULATION_LEVEL(at_reg),
		.I_TAPER_DONE(I_TAPER_DONE), .I_PRECHG_TIMEOUT(I_PRECHG_TIMEOUT), .I_CHG_TIMEOUT(I_CHG_TIMEOUT),
		.I_SUSPEND(I_SUSPEND), .O_STATUS_OUT_A(a), .O_STATUS_OUT_B(b), .O_PROBE_SINK_EN(sink),
		.O_CONDITIONING_EN(cond), .O_REMOVAL_SENSE_EN(sense), .O_FAST_CHARGE_EN(fast), .O_TIMER_RESET(tres));
	cafs_pack_model pack (.i_mclk(I_MCLK), .i_present(present), .i_level(lvl), .i_sink_en(sink),
		.i_cond_en(cond), .i_fast_en(fast), .o_above_recharge(rch), .o_above_precondition(pre),
		.o_at_regulation(at_reg));

	// ----------------
	// Helpers
	// ----------------
	task automatic chk(input string what, input logic [5:0] seen, input logic [5:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge I_MCLK);
	endtask
	// Enable high then low again
	task automatic toggle_en();
		I_CHARGE_EN_N <= 1'b1;
		step(3);
		chk("disabled", outs, 6'h00);
		I_CHARGE_EN_N <= 1'b0;
		step(4);
	endtask
	task automatic pulse(input bit pre_to);
		if (pre_to) I_PRECHG_TIMEOUT <= 1'b1;
		else I_CHG_TIMEOUT <= 1'b1;
		step(1);
		I_PRECHG_TIMEOUT <= 1'b0;
		I_CHG_TIMEOUT <= 1'b0;
		step(4);
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_charge();
		I_CHARGE_EN_N <= 1'b0;
		step(4);
		chk("precharge", outs, 6'h24);
		chk("timer resets", 6'(tr_cnt), 6'h01);
		lvl <= 2'h1;
		step(4);
		chk("fast", outs, 6'h21);
		lvl <= 2'h3;
		I_TAPER_DONE <= 1'b1;
		step(4);
		chk("done", outs, 6'h10);
	endtask
	// Bare node: both phases pass, then retries
	task automatic t_absent();
		present <= 1'b0;
		lvl <= 2'h1;
		step(4);
		chk("phase one", outs, 6'h08);
		step(PROBE);
		chk("phase two", outs, 6'h04);
		lvl <= 2'h2;
		step(PROBE);
		chk("absent", outs, 6'h00);
		lvl <= 2'h1;
		I_TAPER_DONE <= 1'b0;
		step(6);
		chk("retry", {5'h00, a}, 6'h01);
		present <= 1'b1;
	endtask
	// Pack present: phase one fails and charging restarts
	task automatic t_fail();
		lvl <= 2'h3;
		I_TAPER_DONE <= 1'b1;
		step(6);
		chk("done", outs, 6'h10);
		lvl <= 2'h1;
		I_TAPER_DONE <= 1'b0;
		step(4);
		chk("probe", outs, 6'h08);
		step(PROBE + 4);
		chk("restart", {4'h0, a, sink}, 6'h02);
	endtask
	task automatic t_faults();
		lvl <= 2'h2;
		step(4);
		pulse(1'b0);
		step(20);
		chk("fault high", outs, 6'h00);
		lvl <= 2'h1;
		step(4);
		chk("fault cleared", outs, 6'h08);
		toggle_en();
		pulse(1'b0);
		step(20);
		chk("fault low", outs, 6'h02);
		lvl <= 2'h2;
		step(4);
		chk("sense off", outs, 6'h00);
		toggle_en();
		chk("cleared", {5'h00, a}, 6'h01);
		lvl <= 2'h0;
		toggle_en();
		chk("precharge", outs, 6'h24);
		pulse(1'b1);
		chk("precharge fault", {3'h0, a, b, cond}, 6'h00);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		step(10);
		chk("in reset", outs, 6'h00);
		I_RESET <= 1'b0;
		step(1);
		t_charge();
		t_absent();
		t_fail();
		t_faults();
		print_verdict();
	end
endmodule

// >>> cafs_timer_if.sv
`timescale 1ns/1ps
// Probe interval timer handshake
interface cafs_timer_if;
	logic start;
	logic expired;
	modport ctrl(output start, input expired);
	modport tmr(input start, output expired);
endinterface
